/* File: imt_defs.vh */
// imt_defs.vh: register offsets, field positions, reset values and bit
// indices for the i2c master transmit block.
// assumes inclusion by bare name from the design file.
`ifndef IMT_DEFS_VH
`define IMT_DEFS_VH

// register offsets on the plain register port
`define IMT_ADDR_TXBUF   4'h0
`define IMT_ADDR_CTRL2   4'h1
`define IMT_ADDR_STATUS  4'h2
`define IMT_ADDR_BAUD    4'h3

// control two fields
`define IMT_CTRL_START   0
`define IMT_CTRL_RESTART 1
`define IMT_CTRL_STOP    2
`define IMT_CTRL_ACK_STATUS_BIT 6

// status fields
`define IMT_ST_BF        0
`define IMT_ST_IRQ       1
`define IMT_ST_WRITE_COLLISION_FLAG      2
`define IMT_ST_BUSY      3

// reset values
`define IMT_BAUD_RESET   8'h09
`define IMT_ZERO8        8'h00

// bit indices in a byte frame
`define IMT_LAST_DATA    4'h7
`define IMT_ACK_BIT      4'h8

`endif

/* File: imt_master_tx.v */
// imt_master_tx.v: i2c master transmit path with start, stop and restart.
// assumes clk_sys at 20 MHz, external pull-ups on scl and sda, and
// software that clears the collision and interrupt flags itself.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "imt_defs.vh"

module imt_master_tx (
    input wire clk_sys,
    input wire sys_rst,
    input wire clk_en,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe_n,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    output wire serial_irq_out
);

    // states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_BIT = 3'd2;
    localparam [2:0] ST_HOLD = 3'd3;
    localparam [2:0] ST_STOP = 3'd4;
    localparam [2:0] ST_RSTART = 3'd5;

    reg [2:0] state;
    reg [1:0] phase;
    reg [7:0] baud_cnt;
    reg [7:0] baud_reload;
    reg [7:0] tx_buffer_reg;
    reg [7:0] byte_shift_reg;
    reg [3:0] bit_idx;
    reg buffer_full_flag;
    reg ack_status_bit;
    reg serial_irq_flag;
    reg write_collision_flag;
    reg start_request_bit;
    reg stop_request_bit;
    reg restart_request_bit;
    reg scl_low;
    reg sda_low;

    wire tick;
    wire buf_wr;
    wire ctl_wr;
    wire st_wr;
    wire shifting;

    // one baud rollover period ends when the counter reaches zero
    assign tick = (baud_cnt == `IMT_ZERO8);
    assign buf_wr = reg_wr && (reg_addr == `IMT_ADDR_TXBUF);
    assign ctl_wr = reg_wr && (reg_addr == `IMT_ADDR_CTRL2);
    assign st_wr = reg_wr && (reg_addr == `IMT_ADDR_STATUS);
    assign shifting = (state != ST_IDLE);

    // open drain
    // pins only ever pull low; a high level comes from the pull-up
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = ~scl_low;
    assign sda_oe_n = ~sda_low;
    assign serial_irq_out = serial_irq_flag;

    // register read port, data valid the cycle after the strobe
    always @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rdata <= `IMT_ZERO8;
        else if (clk_en)
        begin
            if (reg_rd)
            begin
                case (reg_addr)
                    `IMT_ADDR_TXBUF:
                        reg_rdata <= tx_buffer_reg;
                    `IMT_ADDR_CTRL2:
                        reg_rdata <= {1'b0, ack_status_bit, 3'b000,
                                      stop_request_bit,
                                      restart_request_bit,
                                      start_request_bit};
                    `IMT_ADDR_STATUS:
                        reg_rdata <= {4'h0, shifting,
                                      write_collision_flag,
                                      serial_irq_flag,
                                      buffer_full_flag};
                    `IMT_ADDR_BAUD:
                        reg_rdata <= baud_reload;
                    default:
                        reg_rdata <= `IMT_ZERO8;
                endcase
            end
            else
                reg_rdata <= `IMT_ZERO8;
        end
    end

    // main sequencer: flags, shifter, baud counter and pin drive
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            phase <= 2'd0;
            baud_cnt <= `IMT_BAUD_RESET;
            baud_reload <= `IMT_BAUD_RESET;
            tx_buffer_reg <= `IMT_ZERO8;
            byte_shift_reg <= `IMT_ZERO8;
            bit_idx <= 4'h0;
            buffer_full_flag <= 1'b0;
            ack_status_bit <= 1'b0;
            serial_irq_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            start_request_bit <= 1'b0;
            stop_request_bit <= 1'b0;
            restart_request_bit <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end
        else if (clk_en)
        begin
            // software clears irq
            // a set later in this cycle overrides this clear
            if (st_wr)
            begin
                if (!reg_wdata[`IMT_ST_IRQ])
                    serial_irq_flag <= 1'b0;
                if (!reg_wdata[`IMT_ST_WRITE_COLLISION_FLAG])
                    write_collision_flag <= 1'b0;
            end
            if (reg_wr && (reg_addr == `IMT_ADDR_BAUD))
                baud_reload <= reg_wdata;
            // requests are only taken while the bus engine is idle
            if (ctl_wr && !shifting)
            begin
                start_request_bit <= reg_wdata[`IMT_CTRL_START];
                restart_request_bit <= reg_wdata[`IMT_CTRL_RESTART];
                stop_request_bit <= reg_wdata[`IMT_CTRL_STOP];
            end
            if (buf_wr && shifting)
                write_collision_flag <= 1'b1;
            baud_cnt <= tick ? baud_reload : baud_cnt - 8'h01;
            case (state)
                ST_IDLE:
                begin
                    baud_cnt <= baud_reload;
                    phase <= 2'd0;
                    // start begins with sda high, scl high
                    if (start_request_bit)
                    begin
                        state <= ST_START;
                        sda_low <= 1'b0;
                        scl_low <= 1'b0;
                    end
                    else if (restart_request_bit)
                    begin
                        state <= ST_RSTART;
                        sda_low <= 1'b0;
                    end
                    else if (stop_request_bit)
                    begin
                        state <= ST_STOP;
                        sda_low <= 1'b1;
                    end
                    // a buffer write alone starts a byte
                    else if (buf_wr)
                    begin
                        tx_buffer_reg <= reg_wdata;
                        byte_shift_reg <= reg_wdata;
                        buffer_full_flag <= 1'b1;
                        bit_idx <= 4'h0;
                        state <= ST_BIT;
                        // first bit placed while scl low
                        sda_low <= ~reg_wdata[7];
                    end
                end
                ST_START, ST_RSTART:
                begin
                    // phase 0: lines high (restart releases sda first)
                    // phase 1: sda falls while scl high
                    // phase 2: start hold before scl falls
                    if (tick)
                    begin
                        phase <= phase + 2'd1;
                        if (phase == 2'd0)
                            scl_low <= 1'b0;
                        else if (phase == 2'd1)
                            sda_low <= 1'b1;
                        else if (phase == 2'd2)
                        begin
                            scl_low <= 1'b1;
                            state <= ST_IDLE;
                            serial_irq_flag <= 1'b1;
                            start_request_bit <= 1'b0;
                            restart_request_bit <= 1'b0;
                        end
                    end
                end
                ST_STOP:
                begin
                    // stop: scl rises, then sda rises
                    if (tick)
                    begin
                        phase <= phase + 2'd1;
                        if (phase == 2'd0)
                            scl_low <= 1'b0;
                        else if (phase == 2'd1)
                        begin
                            sda_low <= 1'b0;
                            state <= ST_IDLE;
                            serial_irq_flag <= 1'b1;
                            stop_request_bit <= 1'b0;
                        end
                    end
                end
                ST_BIT:
                begin
                    // scl low held one baud period
                    if (tick && scl_low)
                    begin
                        scl_low <= 1'b0;
                        // ack sampled as ninth clock rises
                        // zero on ack, one on nack
                        if (bit_idx == `IMT_ACK_BIT)
                            ack_status_bit <= sda_in;
                    end
                    else if (tick && !scl_low)
                    begin
                        // sda only moves after scl is low
                        scl_low <= 1'b1;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    // one cycle of hold after the falling scl edge
                    if (bit_idx == `IMT_LAST_DATA)
                    begin
                        // eighth fall clears full, frees sda
                        buffer_full_flag <= 1'b0;
                        sda_low <= 1'b0;
                        bit_idx <= `IMT_ACK_BIT;
                        state <= ST_BIT;
                    end
                    else if (bit_idx == `IMT_ACK_BIT)
                    begin
                        // irq set, baud stops, scl held low
                        serial_irq_flag <= 1'b1;
                        buffer_full_flag <= 1'b0;
                        state <= ST_IDLE;
                    end
                    else
                    begin
                        // next bit msb first on falling scl
                        byte_shift_reg <= {byte_shift_reg[6:0], 1'b0};
                        sda_low <= ~byte_shift_reg[6];
                        bit_idx <= bit_idx + 4'h1;
                        state <= ST_BIT;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

endmodule // imt_master_tx

/* File: imt_master_tx_monitor.sv */
// imt_master_tx_monitor.sv: pin timing checks for the i2c master.
// assumes the baud reload stays at reset, so a baud period is 10 cycles.
`timescale 1ns/1ps
`include "imt_defs.vh"
module imt_master_tx_monitor (
    input wire clk_sys,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire scl_out,
    input wire scl_oe_n,
    input wire sda_out,
    input wire sda_oe_n,
    input wire serial_irq_out
);
    // one baud period is reload + 1 cycles; the bench keeps the reset reload
    localparam int BAUD_T = `IMT_BAUD_RESET + 1;
    logic cond_win;
    logic irq_q;
    logic scl_q;
    logic [7:0] hi_cnt;
    logic [3:0] fall_cnt;
    wire cwr = reg_wr && reg_addr == `IMT_ADDR_CTRL2;
    wire fall_now = scl_q && !scl_oe_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // window of a start, restart or stop: bus edges differ there
    always @(posedge clk_sys)
    begin
        irq_q <= serial_irq_out;
        scl_q <= scl_oe_n;
        if (sys_rst)
            cond_win <= 1'b0;
        else if (cwr && reg_wdata[2:0] != 3'h0)
            cond_win <= 1'b1;
        else if (serial_irq_out && !irq_q)
            cond_win <= 1'b0;
        // saturates so a long idle high never wraps
        if (sys_rst || !scl_oe_n)
            hi_cnt <= 8'h00;
        else if (hi_cnt != 8'hff)
            hi_cnt <= hi_cnt + 8'h01;
        // clock falls since the last event
        if (sys_rst || (serial_irq_out && !irq_q))
            fall_cnt <= 4'h0;
        else if (fall_now)
            fall_cnt <= fall_cnt + 4'h1;
    end
    sequence start_cond;
        $fell(sda_oe_n) && scl_oe_n;
    endsequence
    sequence stop_cond;
        $rose(sda_oe_n) && scl_oe_n;
    endsequence
    sda_stable_a: assert property (
        !cond_win && scl_oe_n && $past(scl_oe_n) |-> $stable(sda_oe_n))
        else $error("sda moved while scl high");
    sda_change_a: assert property (
        !cond_win && $changed(sda_oe_n) |-> !scl_oe_n)
        else $error("sda changed outside scl low");
    scl_high_a: assert property (
        $fell(scl_oe_n) && !cond_win |-> hi_cnt == BAUD_T)
        else $error("scl high time wrong");
    ack_release_a: assert property (
        $rose(scl_oe_n) && !cond_win && fall_cnt == 4'h8 |-> sda_oe_n)
        else $error("sda not released for ack");
    irq_ninth_a: assert property (
        $rose(serial_irq_out) && !cond_win
        |-> !scl_oe_n && fall_cnt + {3'h0, fall_now} == 4'h9)
        else $error("irq not after ninth clock");
    scl_hold_a: assert property (
        serial_irq_out && !cond_win && !scl_oe_n && !reg_wr |=> !scl_oe_n)
        else $error("scl left low hold");
    open_drain_a: assert property (
        scl_out == 1'b0 && sda_out == 1'b0)
        else $error("line driven high");
    start_gen_a: assert property (
        cwr && reg_wdata[0] && scl_oe_n && sda_oe_n && !cond_win
        |-> ##[1:40] start_cond ##[1:40] $rose(serial_irq_out))
        else $error("start not generated");
    start_hold_a: assert property (
        start_cond |-> ##1 scl_oe_n [*8])
        else $error("start hold too short");
    stop_gen_a: assert property (
        cwr && reg_wdata[2] && !cond_win
        |-> ##[1:60] stop_cond ##[0:20] $rose(serial_irq_out))
        else $error("stop not generated");
endmodule // imt_master_tx_monitor

bind imt_master_tx imt_master_tx_monitor u_mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .serial_irq_out(serial_irq_out));

/* File: imt_i2c_slave.sv */
// imt_i2c_slave.sv: behavioural i2c slave receiving bytes.
// assumes scl and sda are the resolved wired-and bus levels.
`timescale 1ns/1ps
module imt_i2c_slave #(
    parameter logic [6:0] SLV_ADDR = 7'h2a
) (
    input wire clk,
    input wire scl,
    input wire sda,
    input wire ack_en,
    output wire sda_pull,
    output wire [7:0] rx_byte
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic first = 1'b0;
    logic pull = 1'b0;
    logic [3:0] bit_n = 4'h0;
    logic [7:0] sh = 8'h00;
    logic [7:0] rx = 8'h00;
    assign sda_pull = pull;
    assign rx_byte = rx;
    // bus edges seen on the system clock; start rearms the bit count
    always @(posedge clk)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda)
        begin
            bit_n <= 4'hf;
            first <= 1'b1;
        end
        else if (scl && !scl_q && bit_n < 4'h8)
            sh <= {sh[6:0], sda};
        else if (!scl && scl_q)
        begin
            bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
            // ack own address, general call, or any data byte while ack_en is high
            if (bit_n == 4'h7)
            begin
                rx <= sh;
                pull <= first ? (sh[7:1] == SLV_ADDR || sh[7:1] == 7'h00)
                              : ack_en;
            end
            if (bit_n == 4'h8)
            begin
                pull <= 1'b0;
                first <= 1'b0;
            end
        end
    end
endmodule // imt_i2c_slave

/* File: imt_master_tx_tb.sv */
// imt_master_tx_tb.sv: self-checking bench for the i2c master.
// assumes one slave model at address 2a on a pulled-up bus.
`timescale 1ns/1ps
`include "imt_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module imt_master_tx_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ack_en = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] got;
    wire [7:0] reg_rdata;
    wire scl_oe_n;
    wire sda_oe_n;
    wire slv_pull;
    wire irq;
    wire [7:0] rx_byte;
    int num_errors = 0;
    int check_count = 0;
    // wired-and bus: a released line reads high
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & ~slv_pull;
    always #25 clk_sys = ~clk_sys;
    imt_master_tx u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda),
        .sda_out(), .sda_oe_n(sda_oe_n), .serial_irq_out(irq));
    imt_i2c_slave u_slv (.clk(clk_sys), .scl(scl), .sda(sda),
        .ack_en(ack_en), .sda_pull(slv_pull), .rx_byte(rx_byte));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 1000)
        begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(irq, 1'b1)
    endtask
    task automatic cond(input int b);
        wr(`IMT_ADDR_CTRL2, 8'h01 << b);
        wait_irq;
        wr(`IMT_ADDR_STATUS, 8'h00);
    endtask
    task automatic send(input logic [7:0] b, input logic ack);
        wr(`IMT_ADDR_TXBUF, b);
        wait_irq;
        `CHK(rx_byte, b)
        rd(`IMT_ADDR_CTRL2);
        `CHK(got[`IMT_CTRL_ACK_STATUS_BIT], ack)
        wr(`IMT_ADDR_STATUS, 8'h00);
    endtask
    task automatic t_reset;
        rd(`IMT_ADDR_STATUS);
        `CHK(got, 8'h00)
        rd(`IMT_ADDR_BAUD);
        `CHK(got, `IMT_BAUD_RESET)
        // reload write lands; a write with the enable low is frozen out
        wr(`IMT_ADDR_BAUD, 8'h3c);
        rd(`IMT_ADDR_BAUD);
        `CHK(got, 8'h3c)
        clk_en <= 1'b0;
        wr(`IMT_ADDR_BAUD, `IMT_BAUD_RESET);
        clk_en <= 1'b1;
        rd(`IMT_ADDR_BAUD);
        `CHK(got, 8'h3c)
        // restore the reset reload the monitor's timing relies on
        wr(`IMT_ADDR_BAUD, `IMT_BAUD_RESET);
        rd(4'h7);
        `CHK(got, 8'h00)
        `CHK(({scl, sda}), 2'b11)
        $display("reset test done");
    endtask
    // collision mid-byte: second write dropped, flags kept
    task automatic t_addr;
        cond(`IMT_CTRL_START);
        wr(`IMT_ADDR_TXBUF, 8'h54);
        rd(`IMT_ADDR_STATUS);
        `CHK(got, 8'h09)
        wr(`IMT_ADDR_TXBUF, 8'h33);
        wait_irq;
        `CHK(rx_byte, 8'h54)
        rd(`IMT_ADDR_TXBUF);
        `CHK(got, 8'h54)
        rd(`IMT_ADDR_STATUS);
        `CHK(got, 8'h06)
        rd(`IMT_ADDR_CTRL2);
        `CHK(got[`IMT_CTRL_ACK_STATUS_BIT], 1'b0)
        wr(`IMT_ADDR_STATUS, 8'h00);
        rd(`IMT_ADDR_STATUS);
        `CHK(got, 8'h00)
        $display("address test done");
    endtask
    task automatic t_data;
        send(8'ha5, 1'b0);
        ack_en <= 1'b0;
        send(8'h3c, 1'b1);
        ack_en <= 1'b1;
        $display("data test done");
    endtask
    task automatic t_restart;
        cond(`IMT_CTRL_RESTART);
        send(8'h00, 1'b0);
        cond(`IMT_CTRL_RESTART);
        send(8'h30, 1'b1);
        $display("restart test done");
    endtask
    task automatic t_stop;
        cond(`IMT_CTRL_STOP);
        `CHK(({scl, sda}), 2'b11)
        $display("stop test done");
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset;
        t_addr;
        t_data;
        t_restart;
        t_stop;
        summarize;
    end
    // watchdog: the run needs a little over a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        summarize;
    end
endmodule // imt_master_tx_tb
